// [tmr3_pkg.sv]
/*
 timer 3 package: sfr addresses, control bit positions, reset values, divider counts.
 assumes an 8-bit sfr bus with 8-bit addresses.
*/
package tmr3_pkg;
   localparam logic [7:0] ADDR_CTRL   = 8'h91;
   localparam logic [7:0] ADDR_RLD_LO = 8'h92;
   localparam logic [7:0] ADDR_RLD_HI = 8'h93;
   localparam logic [7:0] ADDR_CNT_LO = 8'h94;
   localparam logic [7:0] ADDR_CNT_HI = 8'h95;
   localparam logic [7:0] RST_BYTE    = 8'h00;
   localparam logic [7:0] BYTE_ONES   = 8'hff;
   localparam int BIT_HI_OVF  = 7;
   localparam int BIT_LO_OVF  = 6;
   localparam int BIT_LO_IEN  = 5;
   localparam int BIT_CAP_EN  = 4;
   localparam int BIT_SPLIT   = 3;
   localparam int BIT_RUN     = 2;
   localparam int BIT_CAP_SRC = 1;
   localparam int BIT_EXT_CLK = 0;
   localparam int SYS_DIV     = 12;
   localparam int EXT_DIV     = 8;
endpackage : tmr3_pkg

// [tmr3_prescale.sv]
/*
 prescaler: one-cycle enables at system clock / 12 and external source / 8.
 assumes i_ext_clk is asynchronous and slower than half the system clock.
*/
`timescale 1ns/1ps
module tmr3_prescale
(
   // clock and reset
   input  wire logic  i_sys_clk,
   input  wire logic  i_rst_n,
   // external source
   input  wire logic  i_ext_clk,
   // ticks
   tmr3_tick_if.src   tick
);
   logic [3:0] sys_cnt_q, sys_cnt_d;
   logic [2:0] ext_cnt_q, ext_cnt_d;
   logic [2:0] ext_sync_q, ext_sync_d;
   logic       sys_tick_d, ext_tick_d;
   logic       sys_tick_q, ext_tick_q;
   logic       ext_rise;

   always_comb
   begin
      ext_sync_d = {ext_sync_q[1:0], i_ext_clk};
      // only the second and third stages feed the edge detector
      ext_rise   = ext_sync_q[1] & ~ext_sync_q[2];
      sys_tick_d = (sys_cnt_q == 4'(tmr3_pkg::SYS_DIV - 1));
      sys_cnt_d  = sys_tick_d ? 4'h0 : sys_cnt_q + 4'h1;
      ext_tick_d = ext_rise && (ext_cnt_q == 3'(tmr3_pkg::EXT_DIV - 1));
      ext_cnt_d  = ext_rise ? ext_cnt_q + 3'h1 : ext_cnt_q;
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         sys_cnt_q  <= 4'h0;
         ext_cnt_q  <= 3'h0;
         ext_sync_q <= 3'h0;
         sys_tick_q <= 1'b0;
         ext_tick_q <= 1'b0;
      end
      else
      begin
         sys_cnt_q  <= sys_cnt_d;
         ext_cnt_q  <= ext_cnt_d;
         ext_sync_q <= ext_sync_d;
         sys_tick_q <= sys_tick_d;
         ext_tick_q <= ext_tick_d;
      end
   end

   assign tick.sys_tick = sys_tick_q;
   assign tick.ext_tick = ext_tick_q;
endmodule : tmr3_prescale

// [tmr3_tick_if.sv]
/*
 tick interface between the timer core and its prescaler.
 assumes one system clock domain.
*/
`timescale 1ns/1ps
interface tmr3_tick_if;
   logic sys_tick;
   logic ext_tick;
   modport src (output sys_tick, output ext_tick);
   modport dst (input  sys_tick, input  ext_tick);
endinterface : tmr3_tick_if

// [tmr3_timer.sv]
/*
 timer 3 top: 16-bit or split 8-bit auto-reload counter with capture, on the sfr bus.
 assumes a one-cycle sfr write strobe, combinational read data, capture events
 as asynchronous levels whose rising edge is the event.
*/
// Functional notes
// - in auto-reload mode the low reload register supplies the reloaded low byte.
// - in capture mode the low reload register holds the low count of the last capture.
// - unsplit, the high byte register shows bits 15..8 of the 16-bit count.
// - split, the high byte register is an independent 8-bit timer.
// - without capture, 16-bit overflow from all ones reloads the 16-bit value and sets the high flag.
// - split without capture runs two 8-bit reload counters, run gating only the high one.
// - in capture mode a capture event copies both count bytes to the reload registers and flags it.
// - each half counts on system clock if its select is set, else /12 or external /8; unsplit, only the low select applies.
`timescale 1ns/1ps
module tmr3_timer
(
   // clock and reset
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst_n,
   // sfr bus
   input  wire logic [7:0] i_sfr_addr,
   input  wire logic       i_sfr_wr,
   input  wire logic [7:0] i_sfr_wdata,
   output logic      [7:0] o_sfr_rdata,
   output logic            o_sfr_hit,
   // clock selects from the clock configuration register
   input  wire logic       i_high_half_system_clock_select,
   input  wire logic       i_low_half_system_clock_select,
   // event sources
   input  wire logic       i_ext_clk,
   input  wire logic       i_sof_event,
   input  wire logic       i_lfo_clk,
   // interrupt request
   output logic            o_irq
);
   tmr3_tick_if tick ();

   tmr3_prescale u_prescale
   (
      .i_sys_clk (i_sys_clk),
      .i_rst_n   (i_rst_n),
      .i_ext_clk (i_ext_clk),
      .tick      (tick.src)
   );

   logic [7:0] ctrl_q, ctrl_d;
   logic [7:0] rld_lo_q, rld_lo_d;
   logic [7:0] rld_hi_q, rld_hi_d;
   logic [7:0] cnt_lo_q, cnt_lo_d;
   logic [7:0] cnt_hi_q, cnt_hi_d;
   logic [2:0] sof_sync_q, sof_sync_d;
   logic [2:0] lfo_sync_q, lfo_sync_d;
   logic       irq_q, irq_d;
   logic       lo_tick, hi_tick, cap_evt;
   logic       split, cap_en, run;
   logic       lo_ovf, hi_ovf;

   always_comb
   begin
      split  = ctrl_q[tmr3_pkg::BIT_SPLIT];
      cap_en = ctrl_q[tmr3_pkg::BIT_CAP_EN];
      run    = ctrl_q[tmr3_pkg::BIT_RUN];
      // when the select bit is set the half runs every system clock
      lo_tick = i_low_half_system_clock_select | (ctrl_q[tmr3_pkg::BIT_EXT_CLK] ?
                tick.ext_tick : tick.sys_tick);
      hi_tick = i_high_half_system_clock_select | (ctrl_q[tmr3_pkg::BIT_EXT_CLK] ?
                tick.ext_tick : tick.sys_tick);

      ctrl_d   = ctrl_q;
      rld_lo_d = rld_lo_q;
      rld_hi_d = rld_hi_q;
      cnt_lo_d = cnt_lo_q;
      cnt_hi_d = cnt_hi_q;
      lo_ovf   = 1'b0;
      hi_ovf   = 1'b0;

      if (split)
      begin
         // low half free-runs; run control gates the high half only
         if (lo_tick)
         begin
            lo_ovf   = (cnt_lo_q == tmr3_pkg::BYTE_ONES);
            cnt_lo_d = (lo_ovf && !cap_en) ? rld_lo_q : cnt_lo_q + 8'h01;
         end
         if (run && hi_tick)
         begin
            hi_ovf   = (cnt_hi_q == tmr3_pkg::BYTE_ONES);
            cnt_hi_d = (hi_ovf && !cap_en) ? rld_hi_q : cnt_hi_q + 8'h01;
         end
      end
      else if (run && lo_tick)
      begin
         // single 16-bit count, the high byte register is its upper half
         lo_ovf = (cnt_lo_q == tmr3_pkg::BYTE_ONES);
         hi_ovf = lo_ovf && (cnt_hi_q == tmr3_pkg::BYTE_ONES);
         if (hi_ovf && !cap_en)
         begin
            cnt_lo_d = rld_lo_q;
            cnt_hi_d = rld_hi_q;
         end
         else
         begin
            {cnt_hi_d, cnt_lo_d} = {cnt_hi_q, cnt_lo_q} + 16'h0001;
         end
      end

      // software writes go first so that a same-cycle hardware set wins
      if (i_sfr_wr)
      begin
         unique case (i_sfr_addr)
            tmr3_pkg::ADDR_CTRL:   ctrl_d   = i_sfr_wdata;
            tmr3_pkg::ADDR_RLD_LO: rld_lo_d = i_sfr_wdata;
            tmr3_pkg::ADDR_RLD_HI: rld_hi_d = i_sfr_wdata;
            tmr3_pkg::ADDR_CNT_LO: cnt_lo_d = i_sfr_wdata;
            tmr3_pkg::ADDR_CNT_HI: cnt_hi_d = i_sfr_wdata;
            default: ;
         endcase
      end

      if (cap_en && cap_evt)
      begin
         rld_lo_d = cnt_lo_q;
         rld_hi_d = cnt_hi_q;
         ctrl_d[tmr3_pkg::BIT_HI_OVF] = 1'b1;
      end
      if (hi_ovf)
         ctrl_d[tmr3_pkg::BIT_HI_OVF] = 1'b1;
      if (lo_ovf)
         ctrl_d[tmr3_pkg::BIT_LO_OVF] = 1'b1;

   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         ctrl_q     <= tmr3_pkg::RST_BYTE;
         rld_lo_q   <= tmr3_pkg::RST_BYTE;
         rld_hi_q   <= tmr3_pkg::RST_BYTE;
         cnt_lo_q   <= tmr3_pkg::RST_BYTE;
         cnt_hi_q   <= tmr3_pkg::RST_BYTE;
      end
      else
      begin
         ctrl_q     <= ctrl_d;
         rld_lo_q   <= rld_lo_d;
         rld_hi_q   <= rld_hi_d;
         cnt_lo_q   <= cnt_lo_d;
         cnt_hi_q   <= cnt_hi_d;
      end
   end

   // capture event synchronisers: a pin edge reaches the reload registers
   // three clocks after it arrives, which limits how close two events may be
   always_comb
   begin
      sof_sync_d = {sof_sync_q[1:0], i_sof_event};
      lfo_sync_d = {lfo_sync_q[1:0], i_lfo_clk};
      // the first stage may be metastable, so only stages two and three are compared
      cap_evt    = ctrl_q[tmr3_pkg::BIT_CAP_SRC] ? (lfo_sync_q[1] & ~lfo_sync_q[2])
                                                 : (sof_sync_q[1] & ~sof_sync_q[2]);
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         sof_sync_q <= 3'h0;
         lfo_sync_q <= 3'h0;
      end
      else
      begin
         sof_sync_q <= sof_sync_d;
         lfo_sync_q <= lfo_sync_d;
      end
   end

   // flag level as interrupt request; the low flag counts only when enabled.
   // built from the next flag values so that o_irq and the flags move together
   always_comb
   begin
      irq_d = ctrl_d[tmr3_pkg::BIT_HI_OVF] |
              (ctrl_d[tmr3_pkg::BIT_LO_OVF] & ctrl_d[tmr3_pkg::BIT_LO_IEN]);
   end

   always_ff @(posedge i_sys_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         irq_q <= 1'b0;
      end
      else
      begin
         irq_q <= irq_d;
      end
   end

   always_comb
   begin
      o_sfr_hit   = 1'b1;
      o_sfr_rdata = tmr3_pkg::RST_BYTE;
      unique case (i_sfr_addr)
         tmr3_pkg::ADDR_CTRL:   o_sfr_rdata = ctrl_q;
         tmr3_pkg::ADDR_RLD_LO: o_sfr_rdata = rld_lo_q;
         tmr3_pkg::ADDR_RLD_HI: o_sfr_rdata = rld_hi_q;
         tmr3_pkg::ADDR_CNT_LO: o_sfr_rdata = cnt_lo_q;
         tmr3_pkg::ADDR_CNT_HI: o_sfr_rdata = cnt_hi_q;
         default:               o_sfr_hit   = 1'b0;
      endcase
   end

   assign o_irq = irq_q;
endmodule : tmr3_timer

// [tmr3_timer_properties.sv]
/*
 checker for the timer 3 block on its sfr bus and interrupt pin.
 assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module tmr3_timer_chk
(
   // clock and reset
   input  wire logic       i_sys_clk,
   input  wire logic       i_rst_n,
   // sfr bus, selects, interrupt
   input  wire logic [7:0] i_sfr_addr,
   input  wire logic       i_sfr_wr,
   input  wire logic [7:0] i_sfr_wdata,
   input  wire logic [7:0] o_sfr_rdata,
   input  wire logic       o_sfr_hit,
   input  wire logic       i_high_half_system_clock_select,
   input  wire logic       i_low_half_system_clock_select,
   input  wire logic       o_irq
);
   // shadow of the control bits as software writes them; it misses flag bits 7 and 6, which hardware sets
   logic [7:0] ctl_q;
   logic [7:0] ctl_d;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_rst_n);
   always_comb ctl_d = (i_sfr_wr && i_sfr_addr == 8'h91) ? i_sfr_wdata : ctl_q;
   always_ff @(posedge i_sys_clk or negedge i_rst_n)
      if (!i_rst_n) ctl_q <= 8'h00;
      else ctl_q <= ctl_d;
   hit_decode_a: assert property (o_sfr_hit == (i_sfr_addr inside {[8'h91:8'h95]}))
      else $error("hit flag wrong");
   unmapped_zero_a: assert property (!o_sfr_hit |-> o_sfr_rdata == 8'h00)
      else $error("unmapped read not zero");
   irq_from_flags_a: assert property (i_sfr_addr == 8'h91
      |-> o_irq == (o_sfr_rdata[7] | (o_sfr_rdata[6] & o_sfr_rdata[5])))
      else $error("irq does not follow flags");
   irq_drop_cause_a: assert property ($fell(o_irq) |-> $past(i_sfr_wr && i_sfr_addr == 8'h91))
      else $error("irq fell without control write");
   ctrl_write_a: assert property (i_sfr_wr && i_sfr_addr == 8'h91 ##1 i_sfr_addr == 8'h91
      |-> o_sfr_rdata[5:0] == $past(i_sfr_wdata[5:0]))
      else $error("control write lost");
   reload_write_a: assert property (i_sfr_wr && i_sfr_addr == 8'h92 && !ctl_q[4]
      ##1 i_sfr_addr == 8'h92 |-> o_sfr_rdata == $past(i_sfr_wdata))
      else $error("reload write lost");
   low_counts_a: assert property (i_sfr_addr == 8'h94 && !i_sfr_wr && i_low_half_system_clock_select
      && !ctl_q[4] && (ctl_q[2] | ctl_q[3]) && o_sfr_rdata != 8'hff ##1 i_sfr_addr == 8'h94
      |-> o_sfr_rdata == $past(o_sfr_rdata) + 8'h01)
      else $error("low count not stepping");
   high_held_a: assert property (i_sfr_addr == 8'h95 && !i_sfr_wr && ctl_q[3] && !ctl_q[2]
      && !ctl_q[4] ##1 i_sfr_addr == 8'h95 |-> $stable(o_sfr_rdata))
      else $error("stopped high timer moved");
   irq_seen_c: cover property ($rose(o_irq));
   capture_flag_c: cover property (ctl_q[4] && i_sfr_addr == 8'h91 && o_sfr_rdata[7]);
   split_run_c: cover property (ctl_q[3] && ctl_q[2]);
endmodule : tmr3_timer_chk

bind tmr3_timer tmr3_timer_chk i_chk (.*);

// [tmr3_timer_tb.sv]
/*
 testbench for timer 3: register access, reload, split, capture and prescale.
 assumes combinational sfr read data and writes that land at the next edge.
*/
`timescale 1ns/1ps
module tmr3_timer_tb;
   logic       clk = 0, rst_n = 0, wr = 0, hs = 0, ls = 0, ext = 0, sof = 0, low_frequency_oscillator = 0;
   logic [7:0] addr = 0, wd = 0;
   logic [7:0] rd, v, q, rl, rh, h;
   logic       hit, irq;
   int         mismatches = 0, samples_checked = 0, cyc = 0, n;
   tmr3_timer i_dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_sfr_addr(addr), .i_sfr_wr(wr),
      .i_sfr_wdata(wd), .o_sfr_rdata(rd), .o_sfr_hit(hit), .i_high_half_system_clock_select(hs),
      .i_low_half_system_clock_select(ls), .i_ext_clk(ext), .i_sof_event(sof), .i_lfo_clk(low_frequency_oscillator),
      .o_irq(irq));
   initial forever #5 clk = ~clk;
   initial forever #20 ext = ~ext;
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         mismatches++;
         finish_test();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // waits for the next falling edge; the write is taken at the rising edge after it
   task automatic put(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wd = d;
      wr = 1;
      @(negedge clk);
      wr = 0;
   endtask : put
   task automatic get(input logic [7:0] a, output logic [7:0] r);
      addr = a;
      #1 r = rd;
   endtask : get
   task automatic wait_flag(input int b);
      n = 0;
      do
      begin
         @(negedge clk);
         get(8'h91, q);
         n++;
      end while (!q[b] && n < 60);
      chk(q[b], 8'h01);
   endtask : wait_flag
   function automatic logic [7:0] nxt8(input logic [7:0] c, input logic [7:0] r);
      return (c == 8'hff) ? r : c + 8'h01;
   endfunction : nxt8
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : finish_test
   initial
   begin
      v = $urandom(98484);
      repeat (8) @(negedge clk);
      rst_n = 1;
      for (int a = 8'h90; a < 8'h97; a++)
      begin
         get(a[7:0], q);
         chk(q, 8'h00);
         chk(hit, (a > 8'h90 && a < 8'h96) ? 8'h01 : 8'h00);
         v = $urandom;
         // control keeps run, split and capture off so the count bytes stay at zero
         put(a[7:0], (a == 8'h91) ? (v & 8'he3) : v);
         get(a[7:0], q);
         if (a > 8'h91 && a < 8'h96) chk(q, v);
      end
      rl = $urandom;
      rh = $urandom;
      ls = 1;
      put(8'h92, rl);
      put(8'h93, rh);
      put(8'h94, 8'hfd);
      put(8'h95, 8'hff);
      put(8'h91, 8'h04);
      wait_flag(7);
      get(8'h94, q);
      chk(q, rl);
      get(8'h95, q);
      chk(q, rh);
      @(negedge clk);
      chk(irq, 8'h01);
      put(8'h91, 8'h00);
      @(negedge clk);
      chk(irq, 8'h00);
      hs = 1;
      h = $urandom & 8'h7f;
      put(8'h95, h);
      put(8'h94, 8'hfd);
      put(8'h91, 8'h28);
      wait_flag(6);
      chk(irq, 8'h01);
      get(8'h94, q);
      chk(q, rl);
      get(8'h95, v);
      @(negedge clk);
      get(8'h95, q);
      chk(q, h);
      put(8'h91, 8'h0c);
      for (logic [7:0] a = 8'h94; a < 8'h96; a++)
      begin
         get(a, v);
         @(negedge clk);
         get(a, q);
         chk(q, nxt8(v, a[0] ? rh : rl));
         // address held one more edge so the step assertion sees two samples
         @(negedge clk);
      end
      hs = 0;
      ls = 0;
      for (int s = 0; s < 2; s++)
      begin
         put(8'h91, s ? 8'h12 : 8'h10);
         v = $urandom;
         h = $urandom;
         put(8'h94, v);
         put(8'h95, h);
         {low_frequency_oscillator, sof} = s ? 2'b10 : 2'b01;
         wait_flag(7);
         get(8'h92, q);
         chk(q, v);
         get(8'h93, q);
         chk(q, h);
         {low_frequency_oscillator, sof} = 2'b00;
         put(8'h91, 8'h00);
      end
      for (int m = 0; m < 2; m++)
      begin
         put(8'h94, 8'h00);
         put(8'h91, m ? 8'h05 : 8'h04);
         get(8'h94, v);
         repeat (m ? 64 : 36) @(negedge clk);
         get(8'h94, q);
         chk(q - v, m ? 8'h02 : 8'h03);
      end
      finish_test();
   end
endmodule : tmr3_timer_tb
